// file: pkg/sdram_ctl_pkg.sv
// constants and types for the sdram command and refresh controller
// How it works
// - another bank may be commanded during auto precharge without cutting its data
// - after auto precharge no command to that bank until trp elapses
// - never terminate write bursts or auto-precharge read bursts; the code blocks burst stop only after an auto-precharge read
// - commands encoded on cs ras cas we; cs high means nop
// - cke high for every command except self refresh entry
// - load mode: a0-12 op-code, bank 0 mode register, bank 1 extended
// - read and write: a0-8 column, bank inputs bank, a10 auto precharge
// - active: a0-12 row, bank inputs choose one of four banks
// - auto refresh issued at average interval of at most 7.8125 us
// - at most eight postponed; gap between refreshes never above 70.3 us
// - cke held high from refresh command until trfc has elapsed
// - dll relocks on exit; 200 cycles before any read
// - clock stable before cke rises, then only nops for txsnr
// - exit: nops for txsnr, dll reset, 200 more nop cycles
// - dll reset is load mode to base mode register, both bank bits low
package sdram_ctl_pkg;
  localparam int CLK_MHZ       = 125;
  localparam int REFI_NS       = 7812;   // 7.8125 us, rounded down
  localparam int REFI_CYC      = REFI_NS * CLK_MHZ / 1000;
  localparam int REFMAX_NS     = 70300;
  localparam int REFMAX_CYC    = REFMAX_NS * CLK_MHZ / 1000;
  localparam int POST_MAX      = 8;
  localparam int TRFC_NS       = 80;
  localparam int TRFC_CYC      = (TRFC_NS * CLK_MHZ + 999) / 1000;
  localparam int TRP_NS        = 20;
  localparam int TRP_CYC       = (TRP_NS * CLK_MHZ + 999) / 1000;
  localparam int TMRD_CYC      = 2;
  localparam int TXSNR_NS      = 75;
  localparam int TXSNR_CYC     = (TXSNR_NS * CLK_MHZ + 999) / 1000;
  localparam int DLL_CYC       = 200;
  localparam int BURST_CYC     = 4;
  localparam int AP_BIT        = 10;
  localparam int ADDR_W        = 13;
  localparam int CNT_W         = 16;
  // software registers (byte addresses)
  localparam logic [3:0] REG_CMD    = 4'h0;
  localparam logic [3:0] REG_ADDR   = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_CTRL   = 4'hc;
  // command codes written to REG_CMD bits 3:0
  typedef enum logic [3:0] {
    OP_NOP, OP_ACT, OP_RD, OP_WR, OP_BST, OP_PRE, OP_LMR, OP_SRE, OP_SRX
  } op_t;
  // pin encoding: ras cas we
  localparam logic [2:0] ENC_NOP = 3'h7;
  localparam logic [2:0] ENC_ACT = 3'h3;
  localparam logic [2:0] ENC_RD  = 3'h5;
  localparam logic [2:0] ENC_WR  = 3'h4;
  localparam logic [2:0] ENC_BST = 3'h6;
  localparam logic [2:0] ENC_PRE = 3'h2;
  localparam logic [2:0] ENC_REF = 3'h1;
  localparam logic [2:0] ENC_LMR = 3'h0;
  localparam logic [1:0] BA_MR   = 2'h0;
  localparam logic [1:0] BA_EMR  = 2'h1;
endpackage

// file: pkg/ref_req_if.sv
// refresh request handshake between the timer and the sequencer
`timescale 1ns/100ps
interface ref_req_if;
  logic need;
  logic urgent;
  logic done;
  modport timer (output need, output urgent, input done);
  modport seq   (input need, input urgent, output done);
endinterface

// file: hw/refresh_timer.sv
// refresh interval and postponement tracking
`timescale 1ns/100ps
module refresh_timer
  import sdram_ctl_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic enable,
  ref_req_if.timer  req
);
  import sdram_ctl_pkg::*;
  logic [CNT_W-1:0] tick;
  logic [CNT_W-1:0] next_tick;
  logic [3:0]       owed;
  logic [3:0]       next_owed;
  logic [CNT_W-1:0] gap;
  logic [CNT_W-1:0] next_gap;
  ////////////////////////////////////////////////////////////////
  always_comb begin
    next_tick = tick + 1'b1;
    next_owed = owed;
    next_gap  = (gap == '1) ? gap : gap + 1'b1;
    if (tick == CNT_W'(REFI_CYC - 1)) begin
      next_tick = '0;
      if (enable && owed != 4'(POST_MAX)) begin
        next_owed = owed + 1'b1;
      end
    end
    if (req.done) begin
      next_gap = '0;
      if (next_owed != '0) begin
        next_owed = next_owed - 1'b1;
      end
    end
    if (!enable) begin
      next_gap = '0;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tick <= '0;
      owed <= '0;
      gap  <= '0;
    end else begin
      tick <= next_tick;
      owed <= next_owed;
      gap  <= next_gap;
    end
  end
  // urgent once seven refreshes are owed or the absolute gap nears its end
  assign req.need   = owed != '0;
  assign req.urgent = owed >= 4'(POST_MAX - 1) ||
                      gap >= CNT_W'(REFMAX_CYC - REFI_CYC);
endmodule

// file: hw/op_decoder.sv
// maps a software command onto sdram pin encoding
`timescale 1ns/100ps
module op_decoder
  import sdram_ctl_pkg::*;
(
  input  wire logic [3:0] op,
  output logic      [2:0] enc,
  output logic            cke
);
  import sdram_ctl_pkg::*;
  always_comb begin
    cke = 1'b1;
    unique case (op)
      OP_ACT:  enc = ENC_ACT;
      OP_RD:   enc = ENC_RD;
      OP_WR:   enc = ENC_WR;
      OP_BST:  enc = ENC_BST;
      OP_PRE:  enc = ENC_PRE;
      OP_LMR:  enc = ENC_LMR;
      OP_SRE: begin
        enc = ENC_REF;
        cke = 1'b0;
      end
      default: enc = ENC_NOP;
    endcase
  end
endmodule

// file: hw/sdram_cmd_ctl.sv
// sdram command sequencer with refresh, self refresh and avalon registers
//
// The register offsets and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/100ps
module sdram_cmd_ctl
  import sdram_ctl_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  avsAddress,
  input  wire logic        avsRead,
  input  wire logic        avsWrite,
  input  wire logic [31:0] avsWriteData,
  output logic      [31:0] avsReadData,
  output logic             avsWaitRequest,
  output logic             memCsN,
  output logic             memRasN,
  output logic             memCasN,
  output logic             memWeN,
  output logic             memCke,
  output logic      [1:0]  memBa,
  output logic      [12:0] memAddr,
  output logic      [7:0]  memDm
);
  import sdram_ctl_pkg::*;

  typedef enum {ST_IDLE, ST_WAIT, ST_REF, ST_SELF, ST_XSNR, ST_DLL, ST_DLLWAIT} state_t;

  ref_req_if rq ();

  state_t           state;
  state_t           next_state;
  logic [CNT_W-1:0] waitCnt;
  logic [CNT_W-1:0] next_wait;
  logic [CNT_W-1:0] readHold;
  logic [CNT_W-1:0] next_readHold;
  logic [3:0]       bankBusy;
  logic [3:0]       next_bankBusy;
  logic [3:0]       apPending;
  logic [3:0]       next_apPending;
  logic             lastRdAp;
  logic             next_lastRdAp;
  logic [3:0]       pendOp;
  logic [3:0]       next_pendOp;
  logic             pendValid;
  logic             next_pendValid;
  logic [1:0]       pendBa;
  logic [1:0]       next_pendBa;
  logic [12:0]      pendAddr;
  logic [12:0]      next_pendAddr;
  logic [7:0]       dmReg;
  logic [7:0]       next_dmReg;
  logic             refEn;
  logic             next_refEn;
  logic             errFlag;
  logic             next_errFlag;
  logic [31:0]      rdData;
  logic [31:0]      next_rdData;
  logic             ack;
  logic             next_ack;
  logic             csN;
  logic             next_csN;
  logic [2:0]       enc;
  logic [2:0]       next_enc;
  logic             cke;
  logic             next_cke;
  logic [1:0]       ba;
  logic [1:0]       next_ba;
  logic [12:0]      addr;
  logic [12:0]      next_addr;
  logic             refDone;
  logic             next_refDone;
  logic [2:0]       decEnc;
  logic             decCke;
  logic             busReq;
  logic             isRd;
  logic             apBit;

  refresh_timer u_timer (
    .sys_clk (sys_clk),
    .rst     (rst),
    .enable  (refEn),
    .req     (rq.timer)
  );

  op_decoder u_dec (
    .op  (pendOp),
    .enc (decEnc),
    .cke (decCke)
  );

  assign rq.done = refDone;
  assign busReq  = (avsRead || avsWrite) && !ack;
  assign isRd    = pendOp == OP_RD;
  assign apBit   = pendAddr[AP_BIT];

  ////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, answer on the second edge
  always_comb begin
    next_ack       = busReq;
    next_rdData    = rdData;
    next_dmReg     = dmReg;
    next_refEn     = refEn;
    next_pendAddr  = pendAddr;
    next_pendBa    = pendBa;
    next_pendOp    = pendOp;
    next_pendValid = pendValid;
    next_errFlag   = errFlag;
    if (busReq && avsWrite) begin
      unique case (avsAddress)
        REG_CMD: begin
          if (!pendValid) begin
            next_pendOp    = avsWriteData[3:0];
            next_pendValid = 1'b1;
          end else begin
            next_errFlag = 1'b1;
          end
        end
        REG_ADDR: begin
          next_pendAddr = avsWriteData[12:0];
          next_pendBa   = avsWriteData[17:16];
        end
        REG_CTRL: begin
          next_refEn = avsWriteData[0];
          next_dmReg = avsWriteData[15:8];
          if (avsWriteData[1]) begin
            next_errFlag = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (busReq && avsRead) begin
      unique case (avsAddress)
        REG_ADDR:   next_rdData = {14'h0, pendBa, 3'h0, pendAddr};
        REG_STATUS: next_rdData = {16'h0, apPending, bankBusy, 1'b0, errFlag,
                                   rq.need, pendValid, 4'(state)};
        REG_CTRL:   next_rdData = {16'h0, dmReg, 7'h0, refEn};
        default:    next_rdData = 32'h0;
      endcase
    end
    // self refresh entry must free the slot too, or the exit order is refused
    if (state == ST_IDLE && pendValid && (next_state == ST_WAIT || next_state == ST_SELF)) begin
      next_pendValid = 1'b0;
    end
    if (state == ST_SELF && pendValid && pendOp == OP_SRX) begin
      next_pendValid = 1'b0;
    end
    if (state == ST_IDLE && pendValid && (pendOp == OP_NOP || pendOp == OP_SRX ||
        pendOp > OP_SRX)) begin
      next_pendValid = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // command sequencer
  always_comb begin
    next_state     = state;
    next_wait      = (waitCnt != '0) ? waitCnt - 1'b1 : waitCnt;
    next_readHold  = (readHold != '0) ? readHold - 1'b1 : readHold;
    next_bankBusy  = bankBusy;
    next_apPending = apPending;
    next_lastRdAp  = lastRdAp;
    next_csN       = 1'b1;
    next_enc       = ENC_NOP;
    next_cke       = cke;
    next_ba        = ba;
    next_addr      = addr;
    next_refDone   = 1'b0;
    for (int b = 0; b < 4; b++) begin
      if (apPending[b] && waitCnt == '0) begin
        next_apPending[b] = 1'b0;
        next_bankBusy[b]  = 1'b0;
      end
    end
    unique case (state)
      ST_IDLE: begin
        next_cke = 1'b1;
        if (rq.urgent || (rq.need && !pendValid)) begin
          if (bankBusy == '0) begin
            next_csN     = 1'b0;
            next_enc     = ENC_REF;
            next_wait    = CNT_W'(TRFC_CYC);
            next_refDone = 1'b1;
            next_state   = ST_REF;
          end
        end else if (pendValid && pendOp != OP_NOP && pendOp <= OP_SRE) begin
          if ((isRd || pendOp == OP_WR || pendOp == OP_ACT || pendOp == OP_PRE) &&
              bankBusy[pendBa]) begin
            next_state = ST_IDLE;
          end else if (isRd && readHold != '0) begin
            next_state = ST_IDLE;
          end else if (pendOp == OP_BST && lastRdAp) begin
            next_state = ST_IDLE;
          end else begin
            next_csN  = 1'b0;
            next_enc  = decEnc;
            next_cke  = decCke;
            next_ba   = pendBa;
            next_addr = pendAddr;
            next_wait = CNT_W'(TMRD_CYC);
            if (isRd || pendOp == OP_WR) begin
              next_lastRdAp = isRd && apBit;
              if (apBit) begin
                next_bankBusy[pendBa]  = 1'b1;
                next_apPending[pendBa] = 1'b1;
                next_wait = CNT_W'(BURST_CYC + TRP_CYC);
              end
            end
            if (pendOp == OP_PRE) begin
              next_wait = CNT_W'(TRP_CYC);
            end
            // shared counter: never shorten a running auto precharge
            if (apPending != '0 && waitCnt > next_wait) begin
              next_wait = waitCnt - 1'b1;
            end
            if (pendOp == OP_SRE) begin
              next_state = ST_SELF;
            end else begin
              next_state = ST_WAIT;
            end
          end
        end
      end
      ST_WAIT: begin
        if (waitCnt == '0 || apPending != '0) begin
          next_state = ST_IDLE;
        end
      end
      ST_REF: begin
        next_cke = 1'b1;
        if (waitCnt == '0) begin
          next_state = ST_IDLE;
        end
      end
      ST_SELF: begin
        next_cke = 1'b0;
        if (pendValid && pendOp == OP_SRX) begin
          next_cke   = 1'b1;
          next_wait  = CNT_W'(TXSNR_CYC);
          next_state = ST_XSNR;
        end
      end
      ST_XSNR: begin
        if (waitCnt == '0) begin
          next_state = ST_DLL;
        end
      end
      ST_DLL: begin
        next_csN      = 1'b0;
        next_enc      = ENC_LMR;
        next_ba       = BA_MR;
        next_addr     = 13'h0100;
        next_wait     = CNT_W'(DLL_CYC);
        next_readHold = CNT_W'(DLL_CYC);
        next_state    = ST_DLLWAIT;
      end
      ST_DLLWAIT: begin
        if (waitCnt == '0) begin
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state     <= ST_IDLE;
      waitCnt   <= '0;
      readHold  <= '0;
      bankBusy  <= '0;
      apPending <= '0;
      lastRdAp  <= 1'b0;
      pendOp    <= '0;
      pendValid <= 1'b0;
      pendBa    <= '0;
      pendAddr  <= '0;
      dmReg     <= '0;
      refEn     <= 1'b0;
      errFlag   <= 1'b0;
      rdData    <= '0;
      ack       <= 1'b0;
      csN       <= 1'b1;
      enc       <= ENC_NOP;
      cke       <= 1'b1;
      ba        <= '0;
      addr      <= '0;
      refDone   <= 1'b0;
    end else begin
      state     <= next_state;
      waitCnt   <= next_wait;
      readHold  <= next_readHold;
      bankBusy  <= next_bankBusy;
      apPending <= next_apPending;
      lastRdAp  <= next_lastRdAp;
      pendOp    <= next_pendOp;
      pendValid <= next_pendValid;
      pendBa    <= next_pendBa;
      pendAddr  <= next_pendAddr;
      dmReg     <= next_dmReg;
      refEn     <= next_refEn;
      errFlag   <= next_errFlag;
      rdData    <= next_rdData;
      ack       <= next_ack;
      csN       <= next_csN;
      enc       <= next_enc;
      cke       <= next_cke;
      ba        <= next_ba;
      addr      <= next_addr;
      refDone   <= next_refDone;
    end
  end

  // pins straight from flops
  assign memCsN         = csN;
  assign memRasN        = enc[2];
  assign memCasN        = enc[1];
  assign memWeN         = enc[0];
  assign memCke         = cke;
  assign memBa          = ba;
  assign memAddr        = addr;
  assign memDm          = dmReg;
  assign avsReadData    = rdData;
  assign avsWaitRequest = !ack;
endmodule

// file: test/sdram_cmd_ctl_asserts.sv
// assertions on command pins, refresh and self refresh exit
`timescale 1ns/100ps
module sdram_cmd_ctl_asserts
  import sdram_ctl_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic [3:0]  avsAddress,
  input wire logic        avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic        avsWaitRequest,
  input wire logic        memCsN,
  input wire logic        memRasN,
  input wire logic        memCasN,
  input wire logic        memWeN,
  input wire logic        memCke,
  input wire logic [1:0]  memBa,
  input wire logic [12:0] memAddr
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [2:0]  enc;
  logic        cmd, isRef, refEn, colHot, ckeOld, next_refEn, next_colHot;
  logic [13:0] gap, next_gap;
  logic [9:0]  sinceExit, sinceDll, next_sinceExit, next_sinceDll;
  assign enc = {memRasN, memCasN, memWeN};
  assign cmd = !memCsN;
  assign isRef = cmd && enc == ENC_REF && memCke;
  // exit and dll counters saturate so a long idle spell never wraps into a false hit; gap does not saturate
  always_comb begin
    next_refEn = refEn;
    if (avsWrite && !avsWaitRequest && avsAddress == REG_CTRL) next_refEn = avsWriteData[0];
    next_gap = (isRef || !refEn || !memCke) ? 14'h0 : gap + 14'h1;
    next_colHot = colHot;
    if (cmd && (enc == ENC_WR || enc == ENC_RD)) next_colHot = !memWeN || memAddr[AP_BIT];
    next_sinceExit = (sinceExit == 10'h3ff) ? sinceExit : sinceExit + 10'h1;
    if (memCke && !ckeOld) next_sinceExit = 10'h0;
    next_sinceDll = (sinceDll == 10'h3ff) ? sinceDll : sinceDll + 10'h1;
    if (cmd && enc == ENC_LMR && sinceExit < 10'h64) next_sinceDll = 10'h1;
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      refEn <= 1'b0;
      gap <= 14'h0;
      colHot <= 1'b0;
      ckeOld <= 1'b1;
      sinceExit <= 10'h3ff;
      sinceDll <= 10'h3ff;
    end else begin
      refEn <= next_refEn;
      gap <= next_gap;
      colHot <= next_colHot;
      ckeOld <= memCke;
      sinceExit <= next_sinceExit;
      sinceDll <= next_sinceDll;
    end
  end
  ////////////////////////////////////////
  sequence s_idle;
    memCsN || enc == ENC_NOP;
  endsequence
  sequence s_dll_reset;
    cmd && enc == ENC_LMR && memBa == BA_MR;
  endsequence
  a_exit_nops: assert property ($rose(memCke) |-> s_idle [*8])
    else $error("command during self refresh exit");
  a_dll_reset: assert property ($rose(memCke) |-> ##[10:60] s_dll_reset)
    else $error("no dll reset after exit");
  a_dll_wait_nops: assert property (cmd && enc != ENC_NOP |-> sinceDll >= DLL_CYC)
    else $error("command inside dll wait");
  a_read_after_exit: assert property (cmd && enc == ENC_RD |-> sinceExit >= DLL_CYC)
    else $error("read too soon after exit");
  a_cke_refresh: assert property (isRef |=> memCke [*8])
    else $error("cke dropped during refresh");
  a_cke_cmds: assert property (cmd && enc != ENC_REF |-> memCke)
    else $error("command with cke low");
  a_sr_entry: assert property ($fell(memCke) |-> cmd && enc == ENC_REF)
    else $error("cke fell without self refresh");
  a_refresh_gap: assert property (refEn |-> gap <= REFMAX_CYC)
    else $error("refresh gap too long");
  a_bst_guard: assert property (cmd && enc == ENC_BST |-> !colHot)
    else $error("burst stop after write or auto precharge read");
endmodule
bind sdram_cmd_ctl sdram_cmd_ctl_asserts u_sdram_cmd_ctl_asserts (
  .sys_clk(sys_clk), .rst(rst), .avsAddress(avsAddress), .avsWrite(avsWrite),
  .avsWriteData(avsWriteData), .avsWaitRequest(avsWaitRequest), .memCsN(memCsN),
  .memRasN(memRasN), .memCasN(memCasN), .memWeN(memWeN), .memCke(memCke),
  .memBa(memBa), .memAddr(memAddr));

// file: test/sdram_dev_model.sv
// behavioural memory device seen at the command pins
`timescale 1ns/100ps
module sdram_dev_model
  import sdram_ctl_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        memCsN,
  input  wire logic        memRasN,
  input  wire logic        memCasN,
  input  wire logic        memWeN,
  input  wire logic        memCke,
  input  wire logic [1:0]  memBa,
  input  wire logic [12:0] memAddr,
  input  wire logic [7:0]  memDm,
  output logic      [3:0]  rowOpen,
  output logic      [12:0] modeReg,
  output logic      [7:0]  wrMask,
  output logic             inSelf,
  output logic             earlyRead,
  output logic             tooSoon,
  output int               refCnt
);
  logic [2:0] enc;
  int         dllCnt = DLL_CYC;
  int         cyc = 0;
  int         apEnd [4] = '{default: 0};
  assign enc = {memRasN, memCasN, memWeN};
  initial begin
    {rowOpen, modeReg, wrMask, inSelf, earlyRead, tooSoon} = '0;
    refCnt = 0;
  end
  ////////////////////////////////////////
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (dllCnt < DLL_CYC) dllCnt <= dllCnt + 1;
    if (inSelf) begin
      if (memCke) inSelf <= 1'b0; // all but cke ignored
      dllCnt <= 0; // dll relocks from exit
    end else if (!memCsN) begin // high select is a nop
      if (enc inside {ENC_ACT, ENC_RD, ENC_WR} && cyc < apEnd[memBa]) tooSoon <= 1'b1;
      case (enc)
        ENC_ACT: rowOpen[memBa] <= 1'b1; // other banks untouched
        ENC_RD, ENC_WR: begin // column and bank
          if (enc == ENC_WR) wrMask <= memDm; // set bit inhibits byte
          if (enc == ENC_RD && dllCnt < DLL_CYC) earlyRead <= 1'b1;
          if (memAddr[AP_BIT]) begin // closes after burst, this command only
            rowOpen[memBa] <= 1'b0;
            apEnd[memBa] <= cyc + BURST_CYC + TRP_CYC;
          end
        end
        ENC_PRE: rowOpen <= memAddr[AP_BIT] ? 4'h0 : rowOpen & ~(4'h1 << memBa);
        ENC_REF: begin
          if (memCke) refCnt <= refCnt + 1; // row from own counter
          inSelf <= !memCke;
        end
        ENC_LMR: if (memBa == BA_MR) modeReg <= memAddr;
        default: ; // burst stop leaves row open
      endcase
    end
  end
endmodule

// file: test/ddr_sdram_command_refresh_test.sv
// self-checking bench for the sdram command and refresh controller
`timescale 1ns/100ps
module ddr_sdram_command_refresh_test;
  import sdram_ctl_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  avsAddress = 4'h0;
  logic        avsRead = 1'b0;
  logic        avsWrite = 1'b0;
  logic [31:0] avsWriteData = 32'h0;
  logic [31:0] avsReadData, rdData;
  logic        avsWaitRequest, memCsN, memRasN, memCasN, memWeN, memCke;
  logic        inSelf, earlyRead, tooSoon;
  logic [1:0]  memBa, b;
  logic [12:0] memAddr, modeReg, row;
  logic [7:0]  memDm, wrMask, dm;
  logic [3:0]  rowOpen, expOpen;
  logic [8:0]  col;
  int          refCnt, r0, n, fails, samples_checked;
  always #4 sys_clk = ~sys_clk;
  sdram_cmd_ctl u_sdram_cmd_ctl (
    .sys_clk(sys_clk), .rst(rst), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest), .memCsN(memCsN), .memRasN(memRasN),
    .memCasN(memCasN), .memWeN(memWeN), .memCke(memCke), .memBa(memBa),
    .memAddr(memAddr), .memDm(memDm));
  sdram_dev_model u_sdram_dev_model (
    .sys_clk(sys_clk), .memCsN(memCsN), .memRasN(memRasN), .memCasN(memCasN),
    .memWeN(memWeN), .memCke(memCke), .memBa(memBa), .memAddr(memAddr), .memDm(memDm),
    .rowOpen(rowOpen), .modeReg(modeReg), .wrMask(wrMask), .inSelf(inSelf),
    .earlyRead(earlyRead), .tooSoon(tooSoon), .refCnt(refCnt));
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    if (fails == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // request held until waitrequest is sampled low, released at that same edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    avsAddress <= a;
    avsWrite <= wr;
    avsRead <= !wr;
    avsWriteData <= d;
    @(posedge sys_clk);
    while (avsWaitRequest !== 1'b0 && k < 20) begin
      @(posedge sys_clk);
      k++;
    end
    if (k == 20) begin
      chk("bus wait", 0, 1);
      stop_test();
    end
    rdData = avsReadData;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic issue(input op_t op, input logic [1:0] ba, input logic [12:0] a,
                       input logic [2:0] e);
    int k;
    k = 0;
    bus(1'b1, REG_ADDR, {14'h0, ba, 3'h0, a});
    bus(1'b1, REG_CMD, {28'h0, op});
    while ((memCsN !== 1'b0 || {memRasN, memCasN, memWeN} !== e) && k < 600) begin
      @(posedge sys_clk);
      k++;
    end
    chk("cmd seen", k < 600, 1);
    if (k == 600) stop_test();
    chk("cmd cke", memCke, op != OP_SRE);
    if (e inside {ENC_ACT, ENC_RD, ENC_WR, ENC_LMR} || (e == ENC_PRE && !a[AP_BIT])) begin
      chk("bank", memBa, ba);
      chk("addr", memAddr, a);
    end
    case (e)
      ENC_ACT: expOpen[ba] = 1'b1;
      ENC_RD, ENC_WR: if (a[AP_BIT]) expOpen[ba] = 1'b0;
      ENC_PRE: expOpen = a[AP_BIT] ? 4'h0 : expOpen & ~(4'h1 << ba);
      default: ;
    endcase
    @(posedge sys_clk);
    chk("rows", rowOpen, expOpen);
  endtask
  ////////////////////////////////////////
  initial begin
    void'($urandom(32'h1b82));
    fails = 0;
    samples_checked = 0;
    expOpen = 4'h0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk("idle pins", {memCsN, memRasN, memCasN, memWeN, memCke}, 5'h1f);
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped", rdData, 0);
    dm = 8'($urandom);
    b = 2'($urandom);
    row = 13'($urandom);
    col = 9'($urandom);
    bus(1'b1, REG_CTRL, {16'h0, dm, 8'h0});
    chk("mask pins", memDm, dm);
    issue(OP_ACT, b, row, ENC_ACT);
    issue(OP_WR, b, {4'h0, col}, ENC_WR);
    chk("write mask", wrMask, dm);
    issue(OP_RD, b, {4'h0, col}, ENC_RD);
    issue(OP_BST, b, 13'h0, ENC_BST);
    issue(OP_RD, b, 13'h400 | col, ENC_RD);
    issue(OP_ACT, b ^ 2'h1, row, ENC_ACT);
    issue(OP_ACT, b, ~row, ENC_ACT);
    issue(OP_RD, b, {4'h0, col}, ENC_RD);
    issue(OP_PRE, b, 13'h0, ENC_PRE);
    issue(OP_PRE, 2'h0, 13'h400, ENC_PRE);
    issue(OP_LMR, BA_EMR, row, ENC_LMR);
    issue(OP_LMR, BA_MR, row & 13'h1eff, ENC_LMR);
    chk("mode reg", modeReg, row & 13'h1eff);
    bus(1'b0, REG_ADDR, 32'h0);
    chk("addr reg", rdData, {14'h0, BA_MR, 3'h0, row & 13'h1eff});
    bus(1'b0, REG_CTRL, 32'h0);
    chk("ctrl reg", rdData, {16'h0, dm, 8'h0});
    r0 = refCnt;
    bus(1'b1, REG_CTRL, {16'h0, dm, 8'h1});
    repeat (5 * REFI_CYC) @(posedge sys_clk);
    chk("refresh rate", refCnt - r0 >= 4, 1);
    issue(OP_SRE, 2'h0, 13'h0, ENC_REF);
    chk("self entry", {inSelf, memCke}, 2'b10);
    repeat (50) @(posedge sys_clk);
    bus(1'b1, REG_CMD, {28'h0, OP_SRX});
    n = 0;
    while (modeReg !== 13'h0100 && n < 600) begin
      @(posedge sys_clk);
      n++;
    end
    chk("dll reset", modeReg, 13'h0100);
    if (n == 600) stop_test();
    issue(OP_ACT, b, row, ENC_ACT);
    issue(OP_RD, b, {4'h0, col}, ENC_RD);
    chk("early read", earlyRead, 0);
    chk("bank reuse", tooSoon, 0);
    issue(OP_PRE, 2'h0, 13'h400, ENC_PRE);
    stop_test();
  end
endmodule
